//--- hdl/dbmi_beat_buf.sv
`timescale 1ns/1ps
module dbmi_beat_buf #(
    parameter int W = 18,
    parameter int DEPTH = 2
) (
    input wire logic clk,
    input wire logic rst_n,
    dbmi_stream_if.snk fill,
    dbmi_stream_if.src drain
);
    localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
    localparam int CW = $clog2(DEPTH + 1);
    localparam logic [AW-1:0] LAST = AW'(DEPTH - 1);
    localparam logic [CW-1:0] FULL = CW'(DEPTH);

    logic [W-1:0] mem_reg [DEPTH];
    logic [AW-1:0] wptr_reg;
    logic [AW-1:0] rptr_reg;
    logic [CW-1:0] cnt_reg;
    logic push;
    logic pop;

    // ------------------------------------------------------------
    // Handshake
    // ------------------------------------------------------------
    assign fill.ready = (cnt_reg != FULL);
    assign drain.valid = (cnt_reg != '0);
    assign drain.data = mem_reg[rptr_reg];
    assign push = fill.valid && fill.ready;
    assign pop = drain.valid && drain.ready;

    // ------------------------------------------------------------
    // Storage
    // ------------------------------------------------------------
    always_ff @(posedge clk)
    begin
        if (push)
        begin
            mem_reg[wptr_reg] <= fill.data;
        end
    end

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            wptr_reg <= '0;
            rptr_reg <= '0;
            cnt_reg <= '0;
        end
        else
        begin
            if (push)
            begin
                wptr_reg <= (wptr_reg == LAST) ? '0 : wptr_reg + 1'b1;
            end
            if (pop)
            begin
                rptr_reg <= (rptr_reg == LAST) ? '0 : rptr_reg + 1'b1;
            end
            if (push && !pop)
            begin
                cnt_reg <= cnt_reg + 1'b1;
            end
            else if (pop && !push)
            begin
                cnt_reg <= cnt_reg - 1'b1;
            end
        end
    end
endmodule

//--- hdl/dbmi_lane.sv
`timescale 1ns/1ps
module dbmi_lane
    import dbmi_pkg::*;
(
    input wire dbmi_cmd_t wr_cmd,
    input wire logic wr_inv_en,
    input wire logic mask_en,
    input wire logic [BYTE_W-1:0] wr_byte_in,
    input wire logic wr_pin,
    output logic [BYTE_W-1:0] wr_byte_out,
    output logic wr_keep,
    input wire logic rd_inv_en,
    input wire logic [BYTE_W-1:0] rd_byte_in,
    output logic [BYTE_W-1:0] rd_byte_out,
    output logic rd_flag
);
    logic [3:0] ones_all;
    logic [3:0] ones_upper;

    // ------------------------------------------------------------
    // Ones counts
    // ------------------------------------------------------------
    always_comb
    begin
        ones_all = '0;
        ones_upper = '0;
        for (int i = 0; i < BYTE_W; i++)
        begin
            ones_all = ones_all + 4'(rd_byte_in[i]);
            if (i >= MASK_FIELD_LO)
            begin
                ones_upper = ones_upper + 4'(wr_byte_in[i]);
            end
        end
    end

    // ------------------------------------------------------------
    // Write direction
    // ------------------------------------------------------------
    always_comb
    begin
        wr_byte_out = wr_byte_in;
        wr_keep = 1'b1;
        unique case (wr_cmd)
            CMD_WRITE:
            begin
                // Plain writes only ever invert, never mask
                if (wr_inv_en && wr_pin)
                begin
                    wr_byte_out = ~wr_byte_in;
                end
            end
            CMD_MASKED_WRITE:
            begin
                if (!wr_inv_en)
                begin
                    wr_keep = !(mask_en && wr_pin);
                end
                else if (mask_en && !wr_pin && ones_upper >= 4'(MASK_ONES_MIN))
                begin
                    wr_keep = 1'b0;
                end
                else if (wr_pin)
                begin
                    wr_byte_out = ~wr_byte_in;
                end
            end
            default:
            begin
                wr_keep = 1'b1;
            end
        endcase
    end

    // ------------------------------------------------------------
    // Read direction
    // ------------------------------------------------------------
    always_comb
    begin
        rd_flag = rd_inv_en && (ones_all > 4'(READ_FLAG_ONES));
        rd_byte_out = rd_flag ? ~rd_byte_in : rd_byte_in;
    end
endmodule

//--- hdl/dbmi_pkg.sv
package dbmi_pkg;
    localparam int LANES = 2;
    localparam int BYTE_W = 8;
    localparam int DQ_W = LANES * BYTE_W;
    localparam int WR_INV_BIT = 7;
    localparam int RD_INV_BIT = 6;
    localparam int MASK_EN_BIT = 5;
    localparam int READ_FLAG_ONES = 4;
    localparam int MASK_ONES_MIN = 5;
    localparam int MASK_FIELD_LO = 2;
    localparam int BURST_SHORT = 16;
    localparam int BURST_LONG = 32;
    localparam int MASKED_BURST = 16;
    localparam int CLK_PERIOD_NS = 10;
    localparam int READ_BEAT_NS = 80;
    localparam int READ_BEAT_CYCLES = READ_BEAT_NS / CLK_PERIOD_NS;
    localparam int BEAT_W = DQ_W + LANES;

    typedef enum logic [2:0] {
        CMD_WRITE,
        CMD_MASKED_WRITE,
        CMD_READ,
        CMD_MODE_READ,
        CMD_WR_FIFO,
        CMD_RD_FIFO,
        CMD_RD_CAL
    } dbmi_cmd_t;

    typedef enum logic [1:0] {
        ST_IDLE,
        ST_WRITE,
        ST_READ
    } dbmi_state_t;
endpackage

//--- hdl/dbmi_stream_if.sv
`timescale 1ns/1ps
interface dbmi_stream_if #(parameter int W = 18);
    logic valid;
    logic ready;
    logic [W-1:0] data;
    modport src (output valid, output data, input ready);
    modport snk (input valid, input data, output ready);
endinterface

//--- hdl/dbmi_top.sv
`timescale 1ns/1ps
module dbmi_top
    import dbmi_pkg::*;
#(
    parameter int TRAIN_DEPTH = 16,
    parameter bit MODE_READ_INVERT = 1'b0,
    parameter int BUF_DEPTH = 2
) (
    input wire logic clk,
    input wire logic nrst,
    input wire logic [7:0] mode_register_three,
    input wire logic [7:0] mode_register_thirteen,
    input wire logic cmd_valid,
    input wire dbmi_cmd_t cmd_code,
    input wire logic cmd_long_burst,
    output logic cmd_ready,
    output logic cmd_illegal,
    input wire logic link_strobe_in,
    input wire logic [DQ_W-1:0] dq_in,
    output logic [DQ_W-1:0] dq_out,
    output logic dq_oe,
    input wire logic [LANES-1:0] mask_invert_pin_in,
    output logic [LANES-1:0] mask_invert_pin_out,
    output logic [LANES-1:0] mask_invert_pin_oe,
    output logic read_strobe_out,
    output logic mask_invert_rx_en,
    output logic wr_valid,
    output logic [DQ_W-1:0] wr_data,
    output logic [LANES-1:0] wr_byte_keep,
    input wire logic rd_valid,
    input wire logic [DQ_W-1:0] rd_data,
    input wire logic [LANES-1:0] rd_pattern,
    output logic rd_ready
);
    localparam int TAW = $clog2(TRAIN_DEPTH);
    localparam logic [5:0] BEATS_SHORT = 6'(BURST_SHORT);
    localparam logic [5:0] BEATS_LONG = 6'(BURST_LONG);
    localparam logic [5:0] BEATS_MASKED = 6'(MASKED_BURST);
    localparam logic [3:0] BEAT_TIME = 4'(READ_BEAT_CYCLES - 1);

    // ------------------------------------------------------------
    // Reset release
    // ------------------------------------------------------------
    logic [1:0] rst_sync_reg;
    logic rst_n;

    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
        begin
            rst_sync_reg <= 2'h0;
        end
        else
        begin
            rst_sync_reg <= {rst_sync_reg[0], 1'b1};
        end
    end
    assign rst_n = rst_sync_reg[1];

    // ------------------------------------------------------------
    // Mode bits
    // ------------------------------------------------------------
    logic wr_inv_en;
    logic rd_inv_en;
    logic mask_en;
    logic any_en;

    assign wr_inv_en = mode_register_three[WR_INV_BIT];
    assign rd_inv_en = mode_register_three[RD_INV_BIT];
    assign mask_en = mode_register_thirteen[MASK_EN_BIT];
    assign any_en = wr_inv_en || rd_inv_en || mask_en;

    // ------------------------------------------------------------
    // Link input synchronisers
    // ------------------------------------------------------------
    // Strobe, data and pin pass the same three stages so they stay aligned
    logic [2:0] strobe_sync_reg;
    logic [DQ_W-1:0] dq_s1_reg, dq_s2_reg, dq_s3_reg;
    logic [LANES-1:0] pin_s1_reg, pin_s2_reg, pin_s3_reg;
    logic strobe_level_reg;
    logic beat_edge;

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            strobe_sync_reg <= 3'h0;
            dq_s1_reg <= '0;
            dq_s2_reg <= '0;
            dq_s3_reg <= '0;
            pin_s1_reg <= '0;
            pin_s2_reg <= '0;
            pin_s3_reg <= '0;
        end
        else
        begin
            strobe_sync_reg <= {strobe_sync_reg[1:0], link_strobe_in};
            dq_s1_reg <= dq_in;
            dq_s2_reg <= dq_s1_reg;
            dq_s3_reg <= dq_s2_reg;
            pin_s1_reg <= mask_invert_pin_in;
            pin_s2_reg <= pin_s1_reg;
            pin_s3_reg <= pin_s2_reg;
        end
    end

    // Both strobe edges carry a beat
    assign beat_edge = (strobe_sync_reg[1] == strobe_sync_reg[2])
        && (strobe_sync_reg[2] != strobe_level_reg);

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            strobe_level_reg <= 1'b0;
        end
        else if (beat_edge)
        begin
            strobe_level_reg <= strobe_sync_reg[2];
        end
    end

    // ------------------------------------------------------------
    // Command sequencing
    // ------------------------------------------------------------
    dbmi_stream_if #(.W(BEAT_W)) user_s ();
    dbmi_stream_if #(.W(BEAT_W)) drain_s ();
    dbmi_state_t state_reg;
    dbmi_cmd_t cmd_reg;
    logic [5:0] beats_left_reg;
    logic [3:0] beat_timer_reg;
    logic cmd_take;
    logic is_write_cmd;
    logic wr_beat;
    logic rd_load;
    logic rd_done;

    assign cmd_ready = (state_reg == ST_IDLE);
    assign is_write_cmd = (cmd_code == CMD_WRITE) || (cmd_code == CMD_MASKED_WRITE)
        || (cmd_code == CMD_WR_FIFO);
    // A masked write with masking off is refused and flagged
    assign cmd_take = cmd_valid && cmd_ready
        && !(cmd_code == CMD_MASKED_WRITE && !mask_en);
    assign wr_beat = (state_reg == ST_WRITE) && beat_edge;
    assign rd_load = (state_reg == ST_READ) && (beat_timer_reg == 4'h0)
        && (beats_left_reg != 6'h0) && drain_s.valid;
    assign rd_done = (state_reg == ST_READ) && (beat_timer_reg == 4'h0)
        && (beats_left_reg == 6'h0);

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            state_reg <= ST_IDLE;
            cmd_reg <= CMD_WRITE;
            beats_left_reg <= 6'h0;
            beat_timer_reg <= 4'h0;
            cmd_illegal <= 1'b0;
        end
        else
        begin
            cmd_illegal <= cmd_valid && cmd_ready && !cmd_take;
            unique case (state_reg)
                ST_IDLE:
                begin
                    if (cmd_take)
                    begin
                        cmd_reg <= cmd_code;
                        state_reg <= is_write_cmd ? ST_WRITE : ST_READ;
                        if (cmd_code == CMD_MASKED_WRITE)
                        begin
                            beats_left_reg <= BEATS_MASKED;
                        end
                        else
                        begin
                            beats_left_reg <= cmd_long_burst ? BEATS_LONG : BEATS_SHORT;
                        end
                    end
                end
                ST_WRITE:
                begin
                    if (wr_beat)
                    begin
                        beats_left_reg <= beats_left_reg - 6'h1;
                        if (beats_left_reg == 6'h1)
                        begin
                            state_reg <= ST_IDLE;
                        end
                    end
                end
                ST_READ:
                begin
                    if (rd_load)
                    begin
                        beats_left_reg <= beats_left_reg - 6'h1;
                        beat_timer_reg <= BEAT_TIME;
                    end
                    else if (beat_timer_reg != 4'h0)
                    begin
                        beat_timer_reg <= beat_timer_reg - 4'h1;
                    end
                    else if (rd_done)
                    begin
                        state_reg <= ST_IDLE;
                    end
                end
            endcase
        end
    end

    // ------------------------------------------------------------
    // Read beat buffer
    // ------------------------------------------------------------
    // Two entries let the user run ahead while the beat timer paces beats

    assign user_s.valid = rd_valid;
    assign user_s.data = {rd_pattern, rd_data};
    assign rd_ready = user_s.ready;
    assign drain_s.ready = rd_load;

    dbmi_beat_buf #(.W(BEAT_W), .DEPTH(BUF_DEPTH)) u_buf (
        .clk(clk),
        .rst_n(rst_n),
        .fill(user_s),
        .drain(drain_s)
    );

    // ------------------------------------------------------------
    // Byte lanes
    // ------------------------------------------------------------
    logic [LANES-1:0] wr_pin_used;
    logic [DQ_W-1:0] wr_lane_data;
    logic [LANES-1:0] wr_lane_keep;
    logic [DQ_W-1:0] rd_lane_data;
    logic [LANES-1:0] rd_lane_flag;
    logic lane_rd_inv;

    // Receiver on only where the pin carries meaning for this command
    assign mask_invert_rx_en = (state_reg == ST_WRITE) && (wr_inv_en
        || (cmd_reg == CMD_MASKED_WRITE && mask_en)
        || (cmd_reg == CMD_WR_FIFO && any_en));
    assign wr_pin_used = mask_invert_rx_en ? pin_s3_reg : '0;
    // Without inversion support for mode-register reads the pin reads low
    assign lane_rd_inv = rd_inv_en && ((cmd_reg == CMD_READ)
        || (cmd_reg == CMD_MODE_READ && MODE_READ_INVERT));

    for (genvar g = 0; g < LANES; g++)
    begin : g_lane
        dbmi_lane u_lane (
            .wr_cmd(cmd_reg),
            .wr_inv_en(wr_inv_en),
            .mask_en(mask_en),
            .wr_byte_in(dq_s3_reg[g*BYTE_W +: BYTE_W]),
            .wr_pin(wr_pin_used[g]),
            .wr_byte_out(wr_lane_data[g*BYTE_W +: BYTE_W]),
            .wr_keep(wr_lane_keep[g]),
            .rd_inv_en(lane_rd_inv),
            .rd_byte_in(drain_s.data[g*BYTE_W +: BYTE_W]),
            .rd_byte_out(rd_lane_data[g*BYTE_W +: BYTE_W]),
            .rd_flag(rd_lane_flag[g])
        );
    end

    // ------------------------------------------------------------
    // Training pattern store
    // ------------------------------------------------------------
    logic [LANES-1:0] train_mem [TRAIN_DEPTH];
    logic [TAW-1:0] train_ptr_reg;
    logic train_wr;
    logic train_rd;

    assign train_wr = wr_beat && (cmd_reg == CMD_WR_FIFO);
    assign train_rd = rd_load && (cmd_reg == CMD_RD_FIFO);

    always_ff @(posedge clk)
    begin
        if (train_wr)
        begin
            train_mem[train_ptr_reg] <= wr_pin_used;
        end
    end

    // Pointer wraps so longer bursts reuse the stored pattern
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            train_ptr_reg <= '0;
        end
        else if (cmd_take)
        begin
            train_ptr_reg <= '0;
        end
        else if (train_wr || train_rd)
        begin
            train_ptr_reg <= train_ptr_reg + 1'b1;
        end
    end

    // ------------------------------------------------------------
    // Array-side write beats
    // ------------------------------------------------------------
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            wr_valid <= 1'b0;
            wr_data <= '0;
            wr_byte_keep <= '0;
        end
        else
        begin
            wr_valid <= wr_beat && (cmd_reg != CMD_WR_FIFO);
            if (wr_beat)
            begin
                wr_data <= wr_lane_data;
                wr_byte_keep <= wr_lane_keep;
            end
        end
    end

    // ------------------------------------------------------------
    // Link-side read drive
    // ------------------------------------------------------------
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            dq_out <= '0;
            dq_oe <= 1'b0;
            mask_invert_pin_out <= '0;
            mask_invert_pin_oe <= '0;
            read_strobe_out <= 1'b0;
        end
        else if (rd_load)
        begin
            dq_oe <= 1'b1;
            read_strobe_out <= !read_strobe_out;
            unique case (cmd_reg)
                CMD_RD_FIFO:
                begin
                    dq_out <= drain_s.data[DQ_W-1:0];
                    mask_invert_pin_out <= train_mem[train_ptr_reg];
                    mask_invert_pin_oe <= {LANES{any_en}};
                end
                CMD_RD_CAL:
                begin
                    dq_out <= drain_s.data[DQ_W-1:0];
                    mask_invert_pin_out <= drain_s.data[BEAT_W-1:DQ_W];
                    mask_invert_pin_oe <= {LANES{any_en}};
                end
                default:
                begin
                    dq_out <= rd_lane_data;
                    mask_invert_pin_out <= rd_lane_flag;
                    mask_invert_pin_oe <= {LANES{rd_inv_en}};
                end
            endcase
        end
        else if (rd_done || state_reg != ST_READ)
        begin
            dq_oe <= 1'b0;
            mask_invert_pin_oe <= '0;
            mask_invert_pin_out <= '0;
        end
    end
endmodule

//--- tb/dbmi_ctrl_model.sv
`timescale 1ns/1ps
// ------
// Controller model
// ------
module dbmi_ctrl_model
    import dbmi_pkg::*;
(
    input wire logic clk,
    output logic link_strobe_in = 1'b0,
    output logic [DQ_W-1:0] dq_in = 16'h0000,
    output logic [LANES-1:0] mask_invert_pin_in = 2'h0,
    output logic rd_valid = 1'b0,
    output logic [DQ_W-1:0] rd_data = 16'h0000,
    output logic [LANES-1:0] rd_pattern = 2'h0,
    input wire logic rd_ready
);
    // Strobe moves only inside a burst; each edge is one beat
    task automatic wr_beat(input logic [DQ_W-1:0] d, input logic [LANES-1:0] p);
        @(negedge clk);
        dq_in = d;
        mask_invert_pin_in = p;
        link_strobe_in = ~link_strobe_in;
        repeat (READ_BEAT_CYCLES - 1) @(negedge clk);
    endtask
    // Pauses let the buffer run dry, so reads must stall
    task automatic rd_push(input logic [DQ_W-1:0] d, input logic [LANES-1:0] p, output logic ok);
        ok = 1'b0;
        @(negedge clk);
        if ($urandom_range(3) == 0)
        begin
            rd_valid = 1'b0;
            rd_data = ~rd_data;
            repeat (24) @(negedge clk);
        end
        rd_valid = 1'b1;
        rd_data = d;
        rd_pattern = p;
        for (int i = 0; i < 200 && !ok; i++)
        begin
            ok = rd_ready;
            @(posedge clk);
            if (!ok)
                @(negedge clk);
        end
    endtask
    // Released data and pin lines show the inverse; rd_pattern keeps its stale value
    task automatic let_go();
        @(negedge clk);
        rd_valid = 1'b0;
        rd_data = ~rd_data;
        dq_in = ~dq_in;
        mask_invert_pin_in = ~mask_invert_pin_in;
    endtask
endmodule

//--- tb/dbmi_top_sva.sv
`timescale 1ns/1ps
// ------
// Port checks
// ------
module dbmi_top_sva
    import dbmi_pkg::*;
(
    input wire logic clk,
    input wire logic nrst,
    input wire logic [7:0] mode_register_three,
    input wire logic [7:0] mode_register_thirteen,
    input wire logic cmd_valid,
    input wire dbmi_cmd_t cmd_code,
    input wire logic cmd_ready,
    input wire logic cmd_illegal,
    input wire logic dq_oe,
    input wire logic [LANES-1:0] mask_invert_pin_oe,
    input wire logic read_strobe_out,
    input wire logic mask_invert_rx_en,
    input wire logic wr_valid,
    input wire logic [LANES-1:0] wr_byte_keep
);
    default clocking @(posedge clk); endclocking
    default disable iff (!nrst);
    wire logic take = cmd_valid && cmd_ready;
    wire logic mask = mode_register_thirteen[MASK_EN_BIT];
    wire logic off = !mask && !mode_register_three[WR_INV_BIT]
        && !mode_register_three[RD_INV_BIT];
    refuse_mw_a: assert property (take && cmd_code == CMD_MASKED_WRITE && !mask
        |=> cmd_illegal && cmd_ready) else $error("masked write not refused");
    accept_cmd_a: assert property (take && (cmd_code != CMD_MASKED_WRITE || mask)
        |=> !cmd_ready && !cmd_illegal) else $error("command not taken");
    rx_off_a: assert property (off |-> !mask_invert_rx_en)
        else $error("pin receiver on");
    tx_off_a: assert property (off && $stable(mode_register_three)
        |-> mask_invert_pin_oe == 2'h0) else $error("pin driver on");
    lanes_same_a: assert property (!$onehot(mask_invert_pin_oe))
        else $error("lane drivers differ");
    beat_hold_a: assert property ($changed(read_strobe_out)
        |-> dq_oe ##1 $stable(read_strobe_out) [*7]) else $error("read beat too short");
    wr_pulse_a: assert property (wr_valid |=> !wr_valid)
        else $error("write pulse too long");
    keep_mask_a: assert property (wr_valid && wr_byte_keep != 2'h3 |-> mask)
        else $error("byte dropped without masking");
endmodule
bind dbmi_top dbmi_top_sva u_sva (.*);

//--- tb/tb.sv
`timescale 1ns/1ps
// ------
// Bench
// ------
module tb;
    import dbmi_pkg::*;
    logic clk = 1'b0;
    logic nrst = 1'b0;
    logic [7:0] mode_register_three = 8'h00;
    logic [7:0] mode_register_thirteen = 8'h00;
    logic cmd_valid = 1'b0;
    logic cmd_long_burst = 1'b0;
    dbmi_cmd_t cmd_code = CMD_WRITE;
    logic cmd_ready, cmd_illegal, link_strobe_in, dq_oe, read_strobe_out, mask_invert_rx_en;
    logic wr_valid, rd_valid, rd_ready;
    logic [DQ_W-1:0] dq_in, dq_out, wr_data, rd_data;
    logic [LANES-1:0] mask_invert_pin_in, mask_invert_pin_out, mask_invert_pin_oe;
    logic [LANES-1:0] wr_byte_keep, rd_pattern;
    logic [19:0] x;
    logic strobe_seen = 1'b0;
    logic [19:0] exp_w[$];
    logic [19:0] exp_r[$];
    logic [1:0] fifo_pat[$];
    int fail_count = 0;
    int n_tests = 0;
    always #(CLK_PERIOD_NS / 2) clk = ~clk;
    dbmi_top dut (.*);
    dbmi_ctrl_model ctl (.*);
    task automatic chk(input string what, input logic [19:0] seen, input logic [19:0] want);
        n_tests++;
        if (seen !== want)
        begin
            fail_count++;
            $display("unexpected %s: expected %h, seen %h", what, want, seen);
        end
    endtask
    task automatic close_out();
        if (fail_count == 0 && n_tests > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask
    always @(negedge clk)
    begin
        if (wr_valid === 1'b1)
        begin
            x = exp_w.size() > 0 ? exp_w.pop_front() : 20'h00000;
            chk("wr_byte_keep", 20'(wr_byte_keep), 20'(x[17:16]));
            chk("wr_data", 20'(wr_data & {{8{x[17]}}, {8{x[16]}}}), 20'(x[15:0]));
        end
        if (nrst && read_strobe_out !== strobe_seen)
        begin
            strobe_seen = read_strobe_out;
            x = exp_r.size() > 0 ? exp_r.pop_front() : 20'hFFFFF;
            chk("dq_out", 20'({dq_oe, dq_out}), 20'({1'b1, x[15:0]}));
            chk("pin_oe", 20'(mask_invert_pin_oe), 20'(x[19:18]));
            if (x[18])
                chk("pin_out", 20'(mask_invert_pin_out), 20'(x[17:16]));
        end
    end
    task automatic run(input dbmi_cmd_t c, input logic lng);
        logic [DQ_W-1:0] d, e;
        logic [LANES-1:0] p, q, k, ep;
        logic [7:0] b;
        logic wi, ri, me, ok;
        int n;
        wi = mode_register_three[WR_INV_BIT];
        ri = mode_register_three[RD_INV_BIT];
        me = mode_register_thirteen[MASK_EN_BIT];
        n = !lng ? BURST_SHORT : (c == CMD_MASKED_WRITE ? MASKED_BURST : BURST_LONG);
        @(negedge clk);
        cmd_valid = 1'b1;
        cmd_code = c;
        cmd_long_burst = lng;
        @(negedge clk);
        cmd_valid = 1'b0;
        if (c == CMD_MASKED_WRITE && !me)
        begin
            chk("refusal", 20'({cmd_illegal, cmd_ready}), 20'h3);
            return;
        end
        if (c == CMD_WR_FIFO)
            fifo_pat.delete();
        for (int i = 0; i < n; i++)
        begin
            d = 16'($urandom);
            p = (c == CMD_WRITE && me && !wi) ? 2'h0 : 2'($urandom);
            q = 2'($urandom);
            k = 2'h3;
            ep = c == CMD_RD_CAL ? q : (c == CMD_RD_FIFO ? fifo_pat[i] : 2'h0);
            for (int j = 0; j < LANES; j++)
            begin
                b = d[j*BYTE_W +: BYTE_W];
                if (c == CMD_MASKED_WRITE)
                    k[j] = wi ? p[j] || $countones(b[7:MASK_FIELD_LO]) < MASK_ONES_MIN : !p[j];
                if (c <= CMD_MASKED_WRITE && wi && p[j])
                    b = ~b;
                if (c == CMD_READ && ri && $countones(b) > READ_FLAG_ONES)
                begin
                    b = ~b;
                    ep[j] = 1'b1;
                end
                e[j*BYTE_W +: BYTE_W] = k[j] ? b : 8'h00;
            end
            if (c == CMD_WR_FIFO)
                fifo_pat.push_back(p);
            if (c <= CMD_MASKED_WRITE)
                exp_w.push_back(20'({k, e}));
            if (c <= CMD_MASKED_WRITE || c == CMD_WR_FIFO)
                ctl.wr_beat(d, p);
            else
            begin
                exp_r.push_back({c <= CMD_MODE_READ ? {2{ri}} : {2{wi | ri | me}}, ep, e});
                ctl.rd_push(d, q, ok);
                chk("rd_ready", 20'(ok), 20'h1);
                if (!ok)
                    close_out();
            end
        end
        ctl.let_go();
        for (int i = 0; i < 3000 && cmd_ready !== 1'b1; i++)
            @(negedge clk);
        chk("cmd_ready", 20'(cmd_ready), 20'h1);
        if (cmd_ready !== 1'b1)
            close_out();
        repeat (12) @(negedge clk);
        chk("beats left", 20'(exp_w.size() + exp_r.size()), 20'h0);
    endtask
    initial
    begin
        void'($urandom(90399));
        repeat (5) @(negedge clk);
        nrst = 1'b1;
        repeat (3) @(negedge clk);
        // Spare mode bits are random to show they change nothing
        for (int m = 0; m < 8; m++)
        begin
            mode_register_three = 8'($urandom);
            mode_register_thirteen = 8'($urandom);
            mode_register_thirteen[MASK_EN_BIT] = m[2];
            mode_register_three[WR_INV_BIT] = m[1];
            mode_register_three[RD_INV_BIT] = m[0];
            for (int c = 0; c < 7; c++)
                run(dbmi_cmd_t'(c), m == 7 && c < 3);
        end
        close_out();
    end
endmodule
